// *** hdl/mvp_defs.svh ***
/*
 mvp_defs.svh: register offsets, field positions, reset values, mode
 table figures and timing counts of the mono video packetizer.
 assumes: included by its bare name ahead of the code that uses it.
*/
`ifndef MVP_DEFS_SVH
`define MVP_DEFS_SVH
// register byte offsets
`define MVP_REG_VIDEO_SEL 8'h00
`define MVP_REG_ISO_CTRL  8'h04
`define MVP_REG_ROI_POS   8'h08
`define MVP_REG_ROI_SIZE  8'h0C
`define MVP_REG_BPP       8'h10
`define MVP_REG_MAX_BPP   8'h14
`define MVP_REG_CODING    8'h18
`define MVP_REG_STATUS    8'h1C
// field positions
`define MVP_SEL_RATE   2:0
`define MVP_SEL_MODE   6:4
`define MVP_SEL_FMT    10:8
`define MVP_ISO_EN     0
`define MVP_LO_FIELD   10:0
`define MVP_HI_FIELD   26:16
`define MVP_QUAD_FIELD 10:2
`define MVP_BPP_FIELD  12:0
`define MVP_BPP_QUADS  12:2
`define MVP_CODE_FIELD 2:0
`define MVP_ST_OK      0
`define MVP_ST_BUSY    1
`define MVP_ST_OVER    2
`define MVP_ST_PKTS    28:16
// sensor and reset values
`define MVP_SENSOR_W  11'h500
`define MVP_SENSOR_H  11'h3C0
`define MVP_BPP_RESET 13'h1000
`define MVP_BPP_MIN   13'h0004
// pixel coding identifiers and the customizable mode
`define MVP_CODE_MONO8  3'h0
`define MVP_CODE_MONO16 3'h5
`define MVP_FMT_CUSTOM  3'h7
`define MVP_MODE_CUSTOM 3'h0
// standard {format, mode} selections
`define MVP_F0M1 6'h01
`define MVP_F1M2 6'h0A
`define MVP_F1M5 6'h0D
`define MVP_F1M6 6'h0E
`define MVP_F1M7 6'h0F
`define MVP_F2M2 6'h12
`define MVP_F2M6 6'h16
// image sizes
`define MVP_W320  11'h140
`define MVP_H240  11'h0F0
`define MVP_W800  11'h320
`define MVP_H600  11'h258
`define MVP_W1024 11'h400
`define MVP_H768  11'h300
// packet payload in bytes at frame rate code 0, doubled per code step
`define MVP_BASE_F0M1 13'h024
`define MVP_BASE_F1M2 13'h074
`define MVP_BASE_F1M5 13'h0BC
`define MVP_BASE_F1M6 13'h0E4
`define MVP_BASE_F1M7 13'h174
`define MVP_BASE_F2M2 13'h120
`define MVP_BASE_F2M6 13'h240
`define MVP_RATE0 3'h0
`define MVP_RATE1 3'h1
`define MVP_RATE2 3'h2
`define MVP_RATE3 3'h3
`define MVP_RATE4 3'h4
// timing
`define MVP_CLK_PERIOD_NS 100
`define MVP_ISO_CYCLE_NS  125000
`define MVP_ISO_CYCLES    (`MVP_ISO_CYCLE_NS / `MVP_CLK_PERIOD_NS)
// packet limit and largest payload estimate
`define MVP_PKT_LIMIT  13'h0FFF
`define MVP_MAX_K      34'h00000042C
`define MVP_MAX_SHIFT  33:20
`define MVP_MAX_QUADS  12'h400
`define MVP_MAX16_FULL 13'h09C8
// pixel packing
`define MVP_PIX_W      12
`define MVP_PIX_TOP8   4
`define MVP_YUV_CHROMA 8'h80
`endif

// *** hdl/mvp_pkg.sv ***
/*
 mvp_pkg: types shared by the mono video packetizer modules.
 assumes: compiled before every module of the packetizer.
*/
`default_nettype none
package mvp_pkg;
	typedef enum logic [1:0] {
		PIX_MONO8  = 2'h0,
		PIX_MONO16 = 2'h1,
		PIX_YUV    = 2'h2
	} mvp_pix_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h3,
		ST_SEND = 2'h1
	} mvp_state_type;
	typedef struct packed {
		logic              ok;
		logic [10:0]       w;
		logic [10:0]       h;
		mvp_pix_type       kind;
		logic [12:0]       base;
		logic [2:0]        rmin;
		logic [2:0]        rmax;
	} mvp_mode_type;
endpackage
`default_nettype wire

// *** hdl/mvp_iso_timer.sv ***
/*
 mvp_iso_timer: one-cycle tick at the start of every isochronous
 bus cycle.
 assumes: clk at 10 MHz, reset already synchronised by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mvp_defs.svh"
module mvp_iso_timer (
	input  wire logic clk,
	input  wire logic rst_sync_n,
	output logic      tick
);
	logic [10:0] cnt_reg;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cnt_reg <= 11'h000;
			tick <= 1'b0;
		end else if (cnt_reg == 11'(`MVP_ISO_CYCLES - 1)) begin
			cnt_reg <= 11'h000;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 11'h001;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** hdl/mvp_pixel_pack.sv ***
/*
 mvp_pixel_pack: packs four mono8 or two mono16 or YUV sensor pixels into
 one bus quadlet for the active pixel coding; byte 0 is bits 7:0, the lowest address.
 assumes: pixels are 12 bits, pixel 0 in the low bits of pix.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mvp_defs.svh"
module mvp_pixel_pack (
	input  wire mvp_pkg::mvp_pix_type kind,
	input  wire logic [47:0]          pix,
	output logic [31:0]               quad
);
	logic [31:0] mono8_q;

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_lane
			// top eight of twelve bits, four pixels per quadlet
			assign mono8_q[8*i +: 8] =
				pix[`MVP_PIX_W*i + `MVP_PIX_TOP8 +: 8];
		end
	endgenerate

	always_comb begin
		unique case (kind)
		mvp_pkg::PIX_MONO8: begin
			quad = mono8_q;
		end
		mvp_pkg::PIX_MONO16: begin
			// low byte first, upper nibble zero
			quad = {4'h0, pix[`MVP_PIX_W +: `MVP_PIX_W],
				4'h0, pix[0 +: `MVP_PIX_W]};
		end
		mvp_pkg::PIX_YUV: begin
			// U Y V Y with flat chroma: grey only
			quad = {pix[`MVP_PIX_W + `MVP_PIX_TOP8 +: 8],
				`MVP_YUV_CHROMA,
				pix[`MVP_PIX_TOP8 +: 8], `MVP_YUV_CHROMA};
		end
		default: begin
			quad = 32'h0000_0000;
		end
		endcase
	end
endmodule
`default_nettype wire

// *** hdl/mvp_packetizer.sv ***
/*
 mvp_packetizer: video format selection and isochronous packet framing
 of a monochrome camera, with its register file.
 assumes: a pixel store on the same clock that returns four pixels
 starting at pix_x, pix_y combinationally; a link layer that takes one
 quadlet per clock while iso_valid is high.
*/
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "mvp_defs.svh"
// How it works
// - F0M1: 320x240 YUV, rate codes 0-4
// - YUV output carries grey, flat chroma
// - standard 16-bit: 12 bits, LSB aligned
// - 16-bit pixels go low byte first
// - F1M2: 800x600 mono8, codes 2-3
// - F1M5: 1024x768 mono8, codes 1-3
// - F1M6: 800x600 mono16, codes 1-3
// - F1M7: 1024x768 mono16, codes 1-3
// - F2M2: 1280x960 mono8, codes 0-3
// - F2M6: 1280x960 mono16, codes 0-2
// - standard modes read a centred region
// - F7M0 reads the programmed region
// - F7 payload follows bytes-per-packet setting, capped at the largest payload
// - read-only largest payload for region
// - reset: full region, 4096 bytes per packet
// - frame time is packets times 125 us
// - F7 ignores the frame rate code
// - F7 accepts mono8 and mono16 only
// - F7 mono16: 12 bits, LSB aligned
// - F7 mono16 full region tops 8.15 fps
module mvp_packetizer (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	input  wire logic [47:0] pix_data,
	output logic [10:0]      pix_x,
	output logic [10:0]      pix_y,
	output logic [31:0]      iso_data,
	output logic             iso_valid,
	output logic             iso_pkt_start,
	output logic             iso_pkt_end,
	output logic [12:0]      iso_pkt_len,
	output logic             iso_frame_start,
	output logic             iso_frame_end
);
	logic                   rst_meta_reg, rst_sync_n;
	logic [2:0]             fmt_reg, mode_reg, rate_reg, coding_reg;
	logic                   iso_en_reg;
	logic [10:0]            roi_x_reg, roi_y_reg, roi_w_reg, roi_h_reg;
	logic [12:0]            bpp_reg, max_bpp_reg;
	mvp_pkg::mvp_state_type state_reg;
	mvp_pkg::mvp_mode_type  sm;
	mvp_pkg::mvp_pix_type   cur_kind, f_kind_reg;
	logic                   is_f7, cur_ok, roi_fits, tick;
	logic [10:0]            cur_w, cur_h, cur_x0, cur_y0;
	logic [10:0]            cur_pay_q, f_pay_q_reg, pkt_left_reg;
	logic [21:0]            wh, f7_wh;
	logic [20:0]            cur_fq, fq_left_reg;
	logic [33:0]            max_prod;
	logic [13:0]            max_est;
	logic [11:0]            max_q;
	logic [10:0]            f_x0_reg, f_w_reg, step;
	logic                   first_reg, fstart_reg;
	logic [12:0]            pkt_cnt_reg, last_cnt_reg;
	logic                   over_reg;
	logic [31:0]            packed_q;

	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] off);
		return a == off;
	endfunction

	function automatic logic [10:0] min_q(input logic [10:0] a,
		input logic [20:0] b);
		return (b < 21'(a)) ? b[10:0] : a;
	endfunction

	function automatic mvp_pkg::mvp_mode_type std_mode(
		input logic [2:0] f, input logic [2:0] m);
		mvp_pkg::mvp_mode_type r;
		r = '0;
		r.ok = 1'b1;
		r.kind = mvp_pkg::PIX_MONO8;
		r.w = `MVP_SENSOR_W;
		r.h = `MVP_SENSOR_H;
		r.rmin = `MVP_RATE1;
		r.rmax = `MVP_RATE3;
		case ({f, m})
		`MVP_F0M1: begin
			r.w = `MVP_W320;
			r.h = `MVP_H240;
			r.kind = mvp_pkg::PIX_YUV;
			r.base = `MVP_BASE_F0M1;
			r.rmin = `MVP_RATE0;
			r.rmax = `MVP_RATE4;
		end
		`MVP_F1M2: begin
			r.w = `MVP_W800;
			r.h = `MVP_H600;
			r.base = `MVP_BASE_F1M2;
			r.rmin = `MVP_RATE2;
		end
		`MVP_F1M5: begin
			r.w = `MVP_W1024;
			r.h = `MVP_H768;
			r.base = `MVP_BASE_F1M5;
		end
		`MVP_F1M6: begin
			r.w = `MVP_W800;
			r.h = `MVP_H600;
			r.kind = mvp_pkg::PIX_MONO16;
			r.base = `MVP_BASE_F1M6;
		end
		`MVP_F1M7: begin
			r.w = `MVP_W1024;
			r.h = `MVP_H768;
			r.kind = mvp_pkg::PIX_MONO16;
			r.base = `MVP_BASE_F1M7;
		end
		`MVP_F2M2: begin
			r.base = `MVP_BASE_F2M2;
			r.rmin = `MVP_RATE0;
		end
		`MVP_F2M6: begin
			r.kind = mvp_pkg::PIX_MONO16;
			r.base = `MVP_BASE_F2M6;
			r.rmin = `MVP_RATE0;
			r.rmax = `MVP_RATE2;
		end
		default: begin
			r.ok = 1'b0;
		end
		endcase
		return r;
	endfunction

	// reset is released through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n <= rst_meta_reg;
		end
	end

	mvp_iso_timer u_timer (
		.clk        (clk),
		.rst_sync_n (rst_sync_n),
		.tick       (tick)
	);

	mvp_pixel_pack u_pack (
		.kind (f_kind_reg),
		.pix  (pix_data),
		.quad (packed_q)
	);

	// register writes; strange codings are refused, tiny payloads are raised to the minimum
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fmt_reg <= `MVP_FMT_CUSTOM;
			mode_reg <= `MVP_MODE_CUSTOM;
			rate_reg <= `MVP_RATE0;
			iso_en_reg <= 1'b0;
			roi_x_reg <= 11'h000;
			roi_y_reg <= 11'h000;
			roi_w_reg <= `MVP_SENSOR_W;
			roi_h_reg <= `MVP_SENSOR_H;
			bpp_reg <= `MVP_BPP_RESET;
			coding_reg <= `MVP_CODE_MONO8;
		end else if (reg_wr) begin
			if (hit(reg_addr, `MVP_REG_VIDEO_SEL)) begin
				fmt_reg <= reg_wdata[`MVP_SEL_FMT];
				mode_reg <= reg_wdata[`MVP_SEL_MODE];
				rate_reg <= reg_wdata[`MVP_SEL_RATE];
			end
			if (hit(reg_addr, `MVP_REG_ISO_CTRL))
				iso_en_reg <= reg_wdata[`MVP_ISO_EN];
			if (hit(reg_addr, `MVP_REG_ROI_POS)) begin
				roi_x_reg <= {reg_wdata[`MVP_QUAD_FIELD], 2'h0};
				roi_y_reg <= reg_wdata[`MVP_HI_FIELD];
			end
			if (hit(reg_addr, `MVP_REG_ROI_SIZE)) begin
				roi_w_reg <= {reg_wdata[`MVP_QUAD_FIELD], 2'h0};
				roi_h_reg <= reg_wdata[`MVP_HI_FIELD];
			end
			if (hit(reg_addr, `MVP_REG_BPP)) begin
				if (reg_wdata[`MVP_BPP_FIELD] < `MVP_BPP_MIN)
					bpp_reg <= `MVP_BPP_MIN;
				else
					bpp_reg <= {reg_wdata[`MVP_BPP_QUADS], 2'h0};
			end
			if (hit(reg_addr, `MVP_REG_CODING) &&
				(reg_wdata[`MVP_CODE_FIELD] == `MVP_CODE_MONO8 ||
				reg_wdata[`MVP_CODE_FIELD] == `MVP_CODE_MONO16))
				coding_reg <= reg_wdata[`MVP_CODE_FIELD];
		end
	end

	// active geometry, coding and payload of the selected mode
	always_comb begin
		sm = std_mode(fmt_reg, mode_reg);
		is_f7 = fmt_reg == `MVP_FMT_CUSTOM && mode_reg == `MVP_MODE_CUSTOM;
		f7_wh = roi_w_reg * roi_h_reg;
		roi_fits = roi_w_reg != 11'h000 && roi_h_reg != 11'h000 &&
			12'(roi_x_reg) + 12'(roi_w_reg) <= 12'(`MVP_SENSOR_W) &&
			12'(roi_y_reg) + 12'(roi_h_reg) <= 12'(`MVP_SENSOR_H);
		if (is_f7) begin
			// frame rate code plays no part here
			cur_w = roi_w_reg;
			cur_h = roi_h_reg;
			cur_x0 = roi_x_reg;
			cur_y0 = roi_y_reg;
			cur_kind = (coding_reg == `MVP_CODE_MONO16) ?
				mvp_pkg::PIX_MONO16 : mvp_pkg::PIX_MONO8;
			cur_ok = roi_fits;
			cur_pay_q = (bpp_reg < max_bpp_reg) ?
				bpp_reg[`MVP_BPP_QUADS] : max_bpp_reg[`MVP_BPP_QUADS];
		end else begin
			cur_w = sm.w;
			cur_h = sm.h;
			cur_x0 = 11'((`MVP_SENSOR_W - sm.w) >> 1);
			cur_y0 = 11'((`MVP_SENSOR_H - sm.h) >> 1);
			cur_kind = sm.kind;
			cur_ok = sm.ok && rate_reg >= sm.rmin && rate_reg <= sm.rmax;
			cur_pay_q = 11'(13'(sm.base << rate_reg) >> 2);
		end
		wh = cur_w * cur_h;
		cur_fq = (cur_kind == mvp_pkg::PIX_MONO8) ?
			{1'b0, wh[21:2]} : wh[21:1];
		max_prod = (roi_w_reg != 11'h000 &&
			coding_reg == `MVP_CODE_MONO16) ?
			34'({f7_wh, 1'b0}) * `MVP_MAX_K : 34'(f7_wh) * `MVP_MAX_K;
		max_est = max_prod[`MVP_MAX_SHIFT] + 14'h0001;
		max_q = max_est[13:2] + {11'h000, |max_est[1:0]};
	end

	// payload ceiling: sensor readout bounds the frame rate
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			max_bpp_reg <= `MVP_BPP_RESET;
		else if (max_q > `MVP_MAX_QUADS)
			max_bpp_reg <= `MVP_BPP_RESET;
		else
			max_bpp_reg <= {max_q[10:0], 2'h0};
	end

	assign step = (f_kind_reg == mvp_pkg::PIX_MONO8) ? 11'h004 : 11'h002;

	// packet pacing: a packet opens only on a bus cycle tick
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg <= mvp_pkg::ST_IDLE;
			pkt_left_reg <= 11'h000;
			fq_left_reg <= 21'h000000;
			f_pay_q_reg <= 11'h000;
			f_kind_reg <= mvp_pkg::PIX_MONO8;
			f_x0_reg <= 11'h000;
			f_w_reg <= 11'h000;
			first_reg <= 1'b0;
			fstart_reg <= 1'b0;
		end else begin
			unique case (state_reg)
			mvp_pkg::ST_IDLE: begin
				if (tick && iso_en_reg && cur_ok) begin
					f_pay_q_reg <= cur_pay_q;
					f_kind_reg <= cur_kind;
					f_x0_reg <= cur_x0;
					f_w_reg <= cur_w;
					fq_left_reg <= cur_fq;
					pkt_left_reg <= min_q(cur_pay_q, cur_fq);
					first_reg <= 1'b1;
					fstart_reg <= 1'b1;
					state_reg <= mvp_pkg::ST_SEND;
				end
			end
			mvp_pkg::ST_WAIT: begin
				if (!iso_en_reg) begin
					state_reg <= mvp_pkg::ST_IDLE;
				end else if (tick) begin
					pkt_left_reg <= min_q(f_pay_q_reg, fq_left_reg);
					first_reg <= 1'b1;
					state_reg <= mvp_pkg::ST_SEND;
				end
			end
			mvp_pkg::ST_SEND: begin
				first_reg <= 1'b0;
				fstart_reg <= 1'b0;
				pkt_left_reg <= pkt_left_reg - 11'h001;
				fq_left_reg <= fq_left_reg - 21'h000001;
				if (pkt_left_reg == 11'h001)
					state_reg <= (fq_left_reg == 21'h000001) ?
						mvp_pkg::ST_IDLE : mvp_pkg::ST_WAIT;
			end
			default: begin
				state_reg <= mvp_pkg::ST_IDLE;
			end
			endcase
		end
	end

	// pixel address walks the region row by row
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pix_x <= 11'h000;
			pix_y <= 11'h000;
		end else if (state_reg == mvp_pkg::ST_IDLE) begin
			pix_x <= cur_x0;
			pix_y <= cur_y0;
		end else if (state_reg == mvp_pkg::ST_SEND) begin
			if (pix_x + step >= f_x0_reg + f_w_reg) begin
				pix_x <= f_x0_reg;
				pix_y <= pix_y + 11'h001;
			end else begin
				pix_x <= pix_x + step;
			end
		end
	end

	// link side outputs, one quadlet per clock inside a packet
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			iso_data <= 32'h0000_0000;
			iso_valid <= 1'b0;
			iso_pkt_start <= 1'b0;
			iso_pkt_end <= 1'b0;
			iso_pkt_len <= 13'h0000;
			iso_frame_start <= 1'b0;
			iso_frame_end <= 1'b0;
		end else begin
			iso_valid <= state_reg == mvp_pkg::ST_SEND;
			iso_data <= (state_reg == mvp_pkg::ST_SEND) ?
				packed_q : 32'h0000_0000;
			iso_pkt_start <= state_reg == mvp_pkg::ST_SEND && first_reg;
			iso_frame_start <= state_reg == mvp_pkg::ST_SEND && fstart_reg;
			iso_pkt_end <= state_reg == mvp_pkg::ST_SEND &&
				pkt_left_reg == 11'h001;
			iso_frame_end <= state_reg == mvp_pkg::ST_SEND &&
				pkt_left_reg == 11'h001 && fq_left_reg == 21'h000001;
			if (state_reg == mvp_pkg::ST_SEND && first_reg)
				iso_pkt_len <= {pkt_left_reg, 2'h0};
		end
	end

	// packet count per frame; beyond the limit the host's frame breaks
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pkt_cnt_reg <= 13'h0000;
			last_cnt_reg <= 13'h0000;
			over_reg <= 1'b0;
		end else if (state_reg == mvp_pkg::ST_SEND && first_reg) begin
			pkt_cnt_reg <= fstart_reg ? 13'h0001 : pkt_cnt_reg + 13'h0001;
			if (fstart_reg)
				over_reg <= 1'b0;
			else if (pkt_cnt_reg >= `MVP_PKT_LIMIT)
				over_reg <= 1'b1;
		end else if (iso_frame_end) begin
			last_cnt_reg <= pkt_cnt_reg;
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= 32'h0000_0000;
			if (reg_rd) begin
				if (hit(reg_addr, `MVP_REG_VIDEO_SEL))
					reg_rdata <= {21'h0, fmt_reg, 1'b0, mode_reg,
						1'b0, rate_reg};
				if (hit(reg_addr, `MVP_REG_ISO_CTRL))
					reg_rdata <= {31'h0, iso_en_reg};
				if (hit(reg_addr, `MVP_REG_ROI_POS))
					reg_rdata <= {5'h0, roi_y_reg, 5'h0, roi_x_reg};
				if (hit(reg_addr, `MVP_REG_ROI_SIZE))
					reg_rdata <= {5'h0, roi_h_reg, 5'h0, roi_w_reg};
				if (hit(reg_addr, `MVP_REG_BPP))
					reg_rdata <= {19'h0, bpp_reg};
				if (hit(reg_addr, `MVP_REG_MAX_BPP))
					reg_rdata <= {19'h0, max_bpp_reg};
				if (hit(reg_addr, `MVP_REG_CODING))
					reg_rdata <= {29'h0, coding_reg};
				if (hit(reg_addr, `MVP_REG_STATUS))
					reg_rdata <= {3'h0, last_cnt_reg, 13'h0, over_reg,
						state_reg != mvp_pkg::ST_IDLE, cur_ok};
			end
		end
	end

	// helper: clocks since the last packet opened
	logic [15:0] gap_reg;
	logic        seen_reg;
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			gap_reg <= 16'h0000;
			seen_reg <= 1'b0;
		end else if (iso_pkt_start) begin
			gap_reg <= 16'h0000;
			seen_reg <= 1'b1;
		end else if (gap_reg != 16'hFFFF) begin
			gap_reg <= gap_reg + 16'h0001;
		end
	end

	// helper: quadlets already sent in the open packet; a packet may
	// reach 1024 quadlets, too long for a delay range
	logic [10:0] run_reg;
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			run_reg <= 11'h000;
		else if (iso_pkt_start)
			run_reg <= 11'h001;
		else if (iso_valid)
			run_reg <= run_reg + 11'h001;
		else
			run_reg <= 11'h000;
	end

	sequence s_pkt_open;
		iso_pkt_start && iso_valid;
	endsequence
	sequence s_pkt_close;
		(iso_pkt_end && iso_valid) ##1 !iso_valid;
	endsequence

	AST_PKT_SPACING: assert property (@(posedge clk) disable iff (!rst_sync_n)
		iso_pkt_start && seen_reg |-> gap_reg >= 16'(`MVP_ISO_CYCLES - 1))
		else $error("two packets inside one bus cycle");
	AST_PKT_CLOSES: assert property (@(posedge clk) disable iff (!rst_sync_n)
		iso_valid && !iso_pkt_start |-> 12'(run_reg) < `MVP_MAX_QUADS)
		else $error("packet did not close within 1024 quadlets");
	AST_PKT_TAIL: assert property (@(posedge clk) disable iff (!rst_sync_n)
		iso_pkt_end |-> s_pkt_close)
		else $error("link still valid after the last quadlet");
	AST_MONO16_ZERO: assert property (@(posedge clk) disable iff (!rst_sync_n)
		iso_valid && f_kind_reg == mvp_pkg::PIX_MONO16 |->
		iso_data[31:28] == 4'h0 && iso_data[15:12] == 4'h0 &&
		iso_data[11:0] == $past(pix_data[11:0]))
		else $error("16-bit word not low-byte-first with zero top");
	AST_YUV_GREY: assert property (@(posedge clk) disable iff (!rst_sync_n)
		iso_valid && f_kind_reg == mvp_pkg::PIX_YUV |->
		iso_data[7:0] == `MVP_YUV_CHROMA &&
		iso_data[23:16] == `MVP_YUV_CHROMA)
		else $error("grey YUV carries chroma");
	AST_MONO8_LANE: assert property (@(posedge clk) disable iff (!rst_sync_n)
		iso_valid && f_kind_reg == mvp_pkg::PIX_MONO8 |->
		iso_data[7:0] == $past(pix_data[11:4]))
		else $error("mono8 lane 0 not the first pixel");
	AST_CENTRED: assert property (@(posedge clk) disable iff (!rst_sync_n)
		!is_f7 && cur_ok |->
		12'({cur_x0, 1'b0}) + 12'(cur_w) == 12'(`MVP_SENSOR_W))
		else $error("standard region not centred");
	AST_RATE_IGNORED: assert property (@(posedge clk) disable iff (!rst_sync_n)
		is_f7 && reg_wr && hit(reg_addr, `MVP_REG_VIDEO_SEL) &&
		reg_wdata[`MVP_SEL_FMT] == fmt_reg &&
		reg_wdata[`MVP_SEL_MODE] == mode_reg |=>
		$stable(cur_pay_q) && $stable(cur_ok))
		else $error("frame rate code changed the custom mode");
	AST_MAX16_FULL: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(is_f7 && coding_reg == `MVP_CODE_MONO16 &&
		roi_w_reg == `MVP_SENSOR_W && roi_h_reg == `MVP_SENSOR_H) [*2]
		|-> max_bpp_reg == `MVP_MAX16_FULL)
		else $error("full mono16 payload ceiling wrong");
	AST_LEN_CAP: assert property (@(posedge clk) disable iff (!rst_sync_n)
		s_pkt_open |-> iso_pkt_len <= {f_pay_q_reg, 2'h0} &&
		iso_pkt_len != 13'h0000)
		else $error("packet longer than the payload setting");
endmodule
`default_nettype wire

// *** verification/mvp_host_rx.sv ***
/*
 mvp_host_rx: pixel store and isochronous host receiver model.
 assumes: same clock as the packetizer, reset driven by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module mvp_host_rx (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [10:0] pix_x,
	input  wire logic [10:0] pix_y,
	input  wire logic        iso_pkt_start,
	output logic [47:0]      pix_data,
	output logic [15:0]      pkt_count,
	output logic             gap_err
);
	logic [15:0] gap_reg;
	logic        seen_reg;
	// value {x[7:0], y[3:0]}: the top eight bits differ between neighbours
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			pix_data[12*k +: 12] = {8'(pix_x + 11'(k)), pix_y[3:0]};
		end
	end
	// packets may only start on bus cycle boundaries: gaps are whole cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_reg <= 16'h0001;
			seen_reg <= 1'b0;
			pkt_count <= 16'h0000;
			gap_err <= 1'b0;
		end else if (iso_pkt_start) begin
			if (seen_reg && (gap_reg % 16'h04E2) != 16'h0000) begin
				gap_err <= 1'b1;
			end
			gap_reg <= 16'h0001;
			seen_reg <= 1'b1;
			pkt_count <= pkt_count + 16'h0001;
		end else if (gap_reg != 16'hFFFF) begin
			gap_reg <= gap_reg + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
/*
 tb: self-checking bench of the mono video packetizer.
 assumes: mvp_host_rx stands in for the host and the pixel store.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
	typedef struct packed {
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [7:0]  ra;
		logic [31:0] ex;
		logic        wr;
	} mvp_row_type;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata, iso_data, d;
	logic [47:0] pix_data;
	logic [10:0] pix_x, pix_y;
	logic        iso_valid, iso_pkt_start, iso_pkt_end, gap_err;
	logic        iso_frame_start, iso_frame_end;
	logic [12:0] iso_pkt_len;
	logic [15:0] pkt_count;
	logic [11:0] p0, p1;
	int          bad_count = 0;
	int          n_compared = 0;
	int          cycles = 0;
	mvp_row_type rows [0:23] = '{
		'{8'h00, 32'h0, 8'h10, 32'h1000, 1'b0},
		'{8'h00, 32'h0, 8'h0C, 32'h03C00500, 1'b0},
		'{8'h00, 32'h0, 8'h08, 32'h0, 1'b0},
		'{8'h00, 32'h0, 8'h14, 32'h4E4, 1'b0},
		'{8'h00, 32'h0, 8'h20, 32'h0, 1'b0},
		'{8'h18, 32'h5, 8'h14, 32'h9C8, 1'b1},
		'{8'h18, 32'h3, 8'h18, 32'h5, 1'b1},
		'{8'h14, 32'h0, 8'h14, 32'h9C8, 1'b1},
		'{8'h18, 32'h0, 8'h18, 32'h0, 1'b1},
		'{8'h10, 32'h2, 8'h10, 32'h4, 1'b1},
		'{8'h00, 32'h014, 8'h1C, 32'h1, 1'b1},
		'{8'h00, 32'h015, 8'h1C, 32'h0, 1'b1},
		'{8'h00, 32'h121, 8'h1C, 32'h0, 1'b1},
		'{8'h00, 32'h123, 8'h1C, 32'h1, 1'b1},
		'{8'h00, 32'h150, 8'h1C, 32'h0, 1'b1},
		'{8'h00, 32'h151, 8'h1C, 32'h1, 1'b1},
		'{8'h00, 32'h163, 8'h1C, 32'h1, 1'b1},
		'{8'h00, 32'h164, 8'h1C, 32'h0, 1'b1},
		'{8'h00, 32'h171, 8'h1C, 32'h1, 1'b1},
		'{8'h00, 32'h220, 8'h1C, 32'h1, 1'b1},
		'{8'h00, 32'h224, 8'h1C, 32'h0, 1'b1},
		'{8'h00, 32'h262, 8'h1C, 32'h1, 1'b1},
		'{8'h00, 32'h263, 8'h1C, 32'h0, 1'b1},
		'{8'h00, 32'h700, 8'h1C, 32'h1, 1'b1}
	};
	mvp_packetizer mvp_packetizer_i (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_data(pix_data),
		.pix_x(pix_x), .pix_y(pix_y), .iso_data(iso_data),
		.iso_valid(iso_valid), .iso_pkt_start(iso_pkt_start),
		.iso_pkt_end(iso_pkt_end), .iso_pkt_len(iso_pkt_len),
		.iso_frame_start(iso_frame_start), .iso_frame_end(iso_frame_end));
	mvp_host_rx mvp_host_rx_i (.clk(clk), .rst_n(rst_n), .pix_x(pix_x),
		.pix_y(pix_y), .iso_pkt_start(iso_pkt_start),
		.pix_data(pix_data), .pkt_count(pkt_count), .gap_err(gap_err));
	always #50 clk = ~clk;
	function automatic logic [11:0] px(input int x, input int y);
		return {8'(x), 4'(y)};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrt(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic wait_pkt;
		do begin
			@(posedge clk);
			#1;
		end while (iso_pkt_start !== 1'b1);
	endtask
	task automatic conclude;
		if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ceiling well above the ~14000 cycles the sequence needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			bad_count++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 24; i++) begin
			if (rows[i].wr) wrt(rows[i].wa, rows[i].wd);
			repeat (2) @(posedge clk);
			rd(rows[i].ra, d);
			chk(d, rows[i].ex);
		end
		// small region keeps a frame at 8 packets, far inside the limit
		wrt(8'h18, 32'h5);
		wrt(8'h08, 32'h00030004);
		wrt(8'h0C, 32'h00020008);
		wrt(8'h10, 32'h10);
		wrt(8'h00, 32'h704);
		wrt(8'h04, 32'h1);
		for (int i = 0; i < 8; i++) begin
			wait_pkt();
			p0 = px(4 + 2 * (i % 4), 3 + i / 4);
			p1 = px(5 + 2 * (i % 4), 3 + i / 4);
			chk(iso_data, {4'h0, p1, 4'h0, p0});
			chk(32'(iso_pkt_len), 32'h4);
			chk(32'({iso_valid, iso_pkt_end, iso_frame_start,
				iso_frame_end}), 32'({2'h3, i == 0, i == 7}));
		end
		wrt(8'h04, 32'h0);
		repeat (1300) @(posedge clk);
		chk(32'(pkt_count), 32'h8);
		chk(32'(gap_err), 32'h0);
		rd(8'h1C, d);
		chk(32'(d[28:16]), 32'h8);
		// mono8 on the same region: one quadlet of four pixels per packet
		wrt(8'h18, 32'h0);
		wrt(8'h00, 32'h700);
		wrt(8'h04, 32'h1);
		wait_pkt();
		chk(iso_data, 32'h07060504);
		chk(32'(iso_pkt_len), 32'h4);
		wrt(8'h04, 32'h0);
		wrt(8'h00, 32'h014);
		wrt(8'h04, 32'h1);
		wait_pkt();
		p0 = px(480, 360);
		p1 = px(481, 360);
		chk(iso_data, {p1[11:4], 8'h80, p0[11:4], 8'h80});
		chk(32'(iso_pkt_len), 32'h240);
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(32'(iso_valid), 32'h0);
		chk(32'(iso_pkt_len), 32'h0);
		@(posedge clk) rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(8'h10, d);
		chk(d, 32'h1000);
		rd(8'h00, d);
		chk(d, 32'h700);
		conclude();
	end
endmodule
`default_nettype wire
